// ### common/smsp_pkg.sv
// Package for the SPI master/slave port: register map, field positions, reset values, types.
// Assumes a byte register port with word-spaced indices (byte address = 4 x index).
package smsp_pkg;

  localparam int unsigned ADDR_W = 17;

  // Register indices, byte address is four times the index
  localparam logic [14:0] IDX_MODE = 15'h4030;
  localparam logic [14:0] IDX_FLAG = 15'h4031;
  localparam logic [14:0] IDX_RATE = 15'h4032;
  localparam logic [14:0] IDX_DATA = 15'h4033;

  // Mode and status fields
  localparam int unsigned MS_BUSY  = 7;
  localparam int unsigned MS_ROLE  = 6;
  localparam int unsigned MS_CLOCK_PHASE  = 5;
  localparam int unsigned MS_CLOCK_IDLE_POLARITY  = 4;
  localparam int unsigned MS_SLV   = 3;
  localparam int unsigned MS_RAW   = 2;
  localparam int unsigned MS_SHIFT_REGISTER_EMPTY  = 1;
  localparam int unsigned MS_RECEIVE_BUFFER_EMPTY = 0;

  // Flags and control fields
  localparam int unsigned FC_TCF   = 7;
  localparam int unsigned FC_WRITE_COLLISION_FLAG  = 6;
  localparam int unsigned FC_MODE_FAULT_FLAG  = 5;
  localparam int unsigned FC_OVR   = 4;
  localparam int unsigned FC_WM_HI = 3;
  localparam int unsigned FC_WM_LO = 2;
  localparam int unsigned FC_TRANSMIT_BUFFER_EMPTY = 1;
  localparam int unsigned FC_EN    = 0;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h07;
  localparam logic [7:0] FLAG_RST = 8'h02;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Wire modes
  localparam logic [1:0] WM_3WIRE = 2'h0;
  localparam logic [1:0] WM_MULTI = 2'h1;

  // Frame and filter
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [3:0] LAST_EDGE  = 4'hF;
  localparam int unsigned FILT_LEN  = 3;

  typedef struct packed {
    logic       role;
    logic       clock_phase;
    logic       clock_idle_polarity;
    logic [1:0] wire_mode;
    logic       en;
  } smsp_cfg_s;

  localparam smsp_cfg_s CFG_RST = '{role: MODE_RST[MS_ROLE], clock_phase: MODE_RST[MS_CLOCK_PHASE],
    clock_idle_polarity: MODE_RST[MS_CLOCK_IDLE_POLARITY], wire_mode: FLAG_RST[FC_WM_HI:FC_WM_LO], en: FLAG_RST[FC_EN]};

  typedef enum logic {ST_IDLE, ST_SHIFT} smsp_state_e;

endpackage

// ### rtl/smsp_top.sv
// SPI master/slave port: registers, shift engine, clock divider, pin control.
// Assumes a register master on clk_sys_in and pins resolved from the enables outside.
//
// Overview of operation
// - Busy bit is 1 while a byte shifts, 0 otherwise.
// - Role bit 0 selects slave, 1 selects master driving the clock.
// - Phase and polarity pick idle level and capture and launch edges.
// - Selected bit follows the filtered select input, set while it is low.
// - Raw select pin level is readable as a status bit.
// - Slave shift-empty bit is set only while shifter and both buffers are empty; reads 1 in master.
// - Slave receive-empty bit clears on new byte, sets on read; 1 in master.
// - Completion flag sets after each byte; writing 0 clears it.
// - Data write while transmit buffer full sets collision flag; software clears.
// - Low raw select as master in multi-master mode sets mode fault.
// - Slave byte completing into unread buffer sets overrun flag.
// - Wire mode selects 3-wire, 4-wire input select, or select output.
// - In single-master mode the wire mode low bit drives the select pin.
// - Transmit-empty clears on buffer write, sets when byte enters shifter.
// - Enable bit 0 disables the port; it resets to 0.
// - Master clock rate is system clock over 2 over divider plus one.
// - Data read returns receive buffer; write loads transmit and starts master.
// - Mode fault clears role and enable bits.
// - A colliding data write leaves the transmit buffer unchanged.
// - Bytes shift most significant bit first.
// - In 4-wire slave mode the clock is ignored while not selected.
`timescale 1ns/10ps

module smsp_top #(
  parameter int unsigned FILT_LEN = smsp_pkg::FILT_LEN
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_b_in,
  input  wire logic [smsp_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]                  reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [7:0]                  reg_rdata_out,
  input  wire logic                        sclk_in,
  output logic                             sclk_out,
  output logic                             sclk_oe_b_out,
  input  wire logic                        mosi_in,
  output logic                             mosi_out,
  output logic                             mosi_oe_b_out,
  input  wire logic                        miso_in,
  output logic                             miso_out,
  output logic                             miso_oe_b_out,
  input  wire logic                        slave_select_n_in,
  output logic                             slave_select_n_out,
  output logic                             slave_select_n_oe_b_out
);

  if (FILT_LEN < 2 || FILT_LEN > 8) begin : g_chk
    $error("FILT_LEN must be 2 to 8");
  end

  function automatic logic hit(input logic [smsp_pkg::ADDR_W-1:0] a, input logic [14:0] idx);
    hit = (a[1:0] == 2'h0) && (a[smsp_pkg::ADDR_W-1:2] == idx);
  endfunction

  smsp_pkg::smsp_cfg_s   cfg_r;
  smsp_pkg::smsp_state_e state_r;
  logic [7:0]            rate_r;
  logic [7:0]            txbuf_r;
  logic [7:0]            rxbuf_r;
  logic [7:0]            shreg_r;
  logic [7:0]            div_cnt_r;
  logic [3:0]            edge_cnt_r;
  logic [2:0]            bit_cnt_r;
  logic                  transmit_buffer_empty_r;
  logic                  rx_empty_r;
  logic                  sr_empty_r;
  logic                  tcf_r;
  logic                  write_collision_flag_r;
  logic                  mode_fault_flag_r;
  logic                  ovr_r;
  logic                  sclk_r;
  logic                  dout_r;
  logic                  sclk_s1;
  logic                  sclk_s2;
  logic                  sclk_s3;
  logic                  mosi_s1;
  logic                  mosi_s2;
  logic                  miso_s1;
  logic                  miso_s2;
  logic                  nss_s1;
  logic                  nss_s2;
  logic [FILT_LEN-1:0]   nss_hist_r;
  logic                  nss_filt_r;

  logic       wr_mode;
  logic       wr_flag;
  logic       wr_rate;
  logic       wr_data;
  logic       rd_data;
  logic       busy;
  logic       selected;
  logic       slv_ok;
  logic       m_tog;
  logic       edge_ev;
  logic       lead;
  logic       cap_ev;
  logic       lau_ev;
  logic       sin;
  logic       done_ev;
  logic       load;
  logic       mfault;
  logic       shift_register_empty_v;
  logic       receive_buffer_empty_v;
  logic [7:0] rx_byte;
  logic [7:0] mode_v;
  logic [7:0] flag_v;

  assign wr_mode = reg_wr_in && hit(reg_addr_in, smsp_pkg::IDX_MODE);
  assign wr_flag = reg_wr_in && hit(reg_addr_in, smsp_pkg::IDX_FLAG);
  assign wr_rate = reg_wr_in && hit(reg_addr_in, smsp_pkg::IDX_RATE);
  assign wr_data = reg_wr_in && hit(reg_addr_in, smsp_pkg::IDX_DATA);
  assign rd_data = reg_rd_in && hit(reg_addr_in, smsp_pkg::IDX_DATA);

  assign busy     = (state_r == smsp_pkg::ST_SHIFT);
  // Slave takes part only when selected or in 3-wire mode
  assign selected = (cfg_r.wire_mode == smsp_pkg::WM_3WIRE) || !nss_filt_r;
  assign slv_ok   = cfg_r.en && !cfg_r.role && selected;
  assign m_tog    = cfg_r.en && cfg_r.role && busy && (div_cnt_r == rate_r);
  assign edge_ev  = cfg_r.role ? m_tog : (slv_ok && (sclk_s2 != sclk_s3));
  // Leading edge leaves the idle level
  assign lead     = cfg_r.role ? (sclk_r == cfg_r.clock_idle_polarity) : (sclk_s3 == cfg_r.clock_idle_polarity);
  assign cap_ev   = edge_ev && (lead ^ cfg_r.clock_phase);
  assign lau_ev   = edge_ev && !(lead ^ cfg_r.clock_phase);
  assign sin      = cfg_r.role ? miso_s2 : mosi_s2;
  assign done_ev  = cfg_r.role ? (m_tog && edge_cnt_r == smsp_pkg::LAST_EDGE)
                               : (cap_ev && bit_cnt_r == smsp_pkg::LAST_BIT);
  assign rx_byte  = cap_ev ? {shreg_r[6:0], sin} : shreg_r;
  assign load     = cfg_r.en && !busy && !transmit_buffer_empty_r && (cfg_r.role || sr_empty_r);
  assign mfault   = cfg_r.en && cfg_r.role && cfg_r.wire_mode == smsp_pkg::WM_MULTI && !nss_s2;

  assign shift_register_empty_v  = cfg_r.role || (sr_empty_r && transmit_buffer_empty_r && rx_empty_r);
  assign receive_buffer_empty_v = cfg_r.role || rx_empty_r;
  assign mode_v  = {busy, cfg_r.role, cfg_r.clock_phase, cfg_r.clock_idle_polarity, !nss_filt_r, nss_s2, shift_register_empty_v, receive_buffer_empty_v};
  assign flag_v  = {tcf_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, cfg_r.wire_mode, transmit_buffer_empty_r, cfg_r.en};

  // Pin synchronisers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      nss_s1  <= 1'b1;
      nss_s2  <= 1'b1;
    end else begin
      sclk_s1 <= sclk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
      nss_s1  <= slave_select_n_in;
      nss_s2  <= nss_s1;
    end
  end

  // Select glitch filter
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nss_hist_r <= '1;
      nss_filt_r <= 1'b1;
    end else begin
      nss_hist_r <= {nss_hist_r[FILT_LEN-2:0], nss_s2};
      if (&nss_hist_r) begin
        nss_filt_r <= 1'b1;
      end else if (~|nss_hist_r) begin
        nss_filt_r <= 1'b0;
      end
    end
  end

  // Configuration
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_r  <= smsp_pkg::CFG_RST;
      rate_r <= smsp_pkg::RATE_RST;
    end else begin
      if (wr_mode) begin
        cfg_r.role <= reg_wdata_in[smsp_pkg::MS_ROLE];
        cfg_r.clock_phase <= reg_wdata_in[smsp_pkg::MS_CLOCK_PHASE];
        cfg_r.clock_idle_polarity <= reg_wdata_in[smsp_pkg::MS_CLOCK_IDLE_POLARITY];
      end
      if (wr_flag) begin
        cfg_r.wire_mode <= reg_wdata_in[smsp_pkg::FC_WM_HI:smsp_pkg::FC_WM_LO];
        cfg_r.en        <= reg_wdata_in[smsp_pkg::FC_EN];
      end
      if (mfault) begin
        cfg_r.role <= 1'b0;
        cfg_r.en   <= 1'b0;
      end
      if (wr_rate) begin
        rate_r <= reg_wdata_in;
      end
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tcf_r  <= smsp_pkg::FLAG_RST[smsp_pkg::FC_TCF];
      write_collision_flag_r <= smsp_pkg::FLAG_RST[smsp_pkg::FC_WRITE_COLLISION_FLAG];
      mode_fault_flag_r <= smsp_pkg::FLAG_RST[smsp_pkg::FC_MODE_FAULT_FLAG];
      ovr_r  <= smsp_pkg::FLAG_RST[smsp_pkg::FC_OVR];
    end else begin
      if (done_ev) begin
        tcf_r <= 1'b1;
      end else if (wr_flag && !reg_wdata_in[smsp_pkg::FC_TCF]) begin
        tcf_r <= 1'b0;
      end
      if (wr_data && !transmit_buffer_empty_r) begin
        write_collision_flag_r <= 1'b1;
      end else if (wr_flag && !reg_wdata_in[smsp_pkg::FC_WRITE_COLLISION_FLAG]) begin
        write_collision_flag_r <= 1'b0;
      end
      if (mfault) begin
        mode_fault_flag_r <= 1'b1;
      end else if (wr_flag && !reg_wdata_in[smsp_pkg::FC_MODE_FAULT_FLAG]) begin
        mode_fault_flag_r <= 1'b0;
      end
      if (done_ev && !cfg_r.role && !rx_empty_r) begin
        ovr_r <= 1'b1;
      end else if (wr_flag && !reg_wdata_in[smsp_pkg::FC_OVR]) begin
        ovr_r <= 1'b0;
      end
    end
  end

  // Transmit and receive buffers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      txbuf_r    <= smsp_pkg::DATA_RST;
      rxbuf_r    <= smsp_pkg::DATA_RST;
      transmit_buffer_empty_r    <= smsp_pkg::FLAG_RST[smsp_pkg::FC_TRANSMIT_BUFFER_EMPTY];
      rx_empty_r <= smsp_pkg::MODE_RST[smsp_pkg::MS_RECEIVE_BUFFER_EMPTY];
    end else begin
      if (wr_data && transmit_buffer_empty_r) begin
        txbuf_r <= reg_wdata_in;
        transmit_buffer_empty_r <= 1'b0;
      end else if (load) begin
        transmit_buffer_empty_r <= 1'b1;
      end
      if (done_ev && (cfg_r.role || rx_empty_r)) begin
        rxbuf_r <= rx_byte;
      end
      if (done_ev && !cfg_r.role && rx_empty_r) begin
        rx_empty_r <= 1'b0;
      end else if (rd_data) begin
        rx_empty_r <= 1'b1;
      end
    end
  end

  // Shift engine state
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r    <= smsp_pkg::ST_IDLE;
      sr_empty_r <= smsp_pkg::MODE_RST[smsp_pkg::MS_SHIFT_REGISTER_EMPTY];
      bit_cnt_r  <= '0;
      edge_cnt_r <= '0;
    end else begin
      if (!cfg_r.en || done_ev || (!cfg_r.role && !selected)) begin
        state_r <= smsp_pkg::ST_IDLE;
      end else if (load && cfg_r.role) begin
        state_r <= smsp_pkg::ST_SHIFT;
      end else if (edge_ev && lead && !cfg_r.role) begin
        state_r <= smsp_pkg::ST_SHIFT;
      end
      if (!cfg_r.en || done_ev) begin
        sr_empty_r <= 1'b1;
      end else if (load || edge_ev) begin
        sr_empty_r <= 1'b0;
      end
      if (!cfg_r.en || load || done_ev || (!cfg_r.role && !selected)) begin
        bit_cnt_r <= '0;
      end else if (cap_ev) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (load) begin
        edge_cnt_r <= '0;
      end else if (m_tog) begin
        edge_cnt_r <= edge_cnt_r + 4'h1;
      end
    end
  end

  // Shift register and data out, MSB first
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shreg_r <= smsp_pkg::DATA_RST;
      dout_r  <= 1'b0;
    end else begin
      if (load) begin
        shreg_r <= txbuf_r;
        dout_r  <= txbuf_r[7];
      end else if (cap_ev) begin
        shreg_r <= {shreg_r[6:0], sin};
      end else if (lau_ev) begin
        dout_r <= shreg_r[7];
      end
    end
  end

  // Master clock divider
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt_r <= '0;
      sclk_r    <= smsp_pkg::CFG_RST.clock_idle_polarity;
    end else begin
      if (!busy || !cfg_r.role) begin
        div_cnt_r <= '0;
        sclk_r    <= cfg_r.clock_idle_polarity;
      end else if (m_tog) begin
        div_cnt_r <= '0;
        sclk_r    <= !sclk_r;
      end else begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  // Pin drivers and read port
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_out                <= smsp_pkg::CFG_RST.clock_idle_polarity;
      sclk_oe_b_out           <= 1'b1;
      mosi_out                <= 1'b0;
      mosi_oe_b_out           <= 1'b1;
      miso_out                <= 1'b0;
      miso_oe_b_out           <= 1'b1;
      slave_select_n_out      <= 1'b1;
      slave_select_n_oe_b_out <= 1'b1;
      reg_rdata_out           <= 8'h00;
    end else begin
      sclk_out                <= sclk_r;
      sclk_oe_b_out           <= !(cfg_r.en && cfg_r.role);
      mosi_out                <= dout_r;
      mosi_oe_b_out           <= !(cfg_r.en && cfg_r.role);
      miso_out                <= dout_r;
      miso_oe_b_out           <= !slv_ok;
      slave_select_n_out      <= cfg_r.wire_mode[0];
      slave_select_n_oe_b_out <= !cfg_r.wire_mode[1];
      if (reg_rd_in && hit(reg_addr_in, smsp_pkg::IDX_MODE)) begin
        reg_rdata_out <= mode_v;
      end else if (reg_rd_in && hit(reg_addr_in, smsp_pkg::IDX_FLAG)) begin
        reg_rdata_out <= flag_v;
      end else if (reg_rd_in && hit(reg_addr_in, smsp_pkg::IDX_RATE)) begin
        reg_rdata_out <= rate_r;
      end else if (rd_data) begin
        reg_rdata_out <= rxbuf_r;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  busy_end_a: assert property (done_ev |=> !busy)
    else $error("busy stays set after frame");
  role_pins_a: assert property (cfg_r.en && cfg_r.role |=> !sclk_oe_b_out && !mosi_oe_b_out)
    else $error("master does not drive clock");
  idle_park_a: assert property (!busy && cfg_r.role ##1 !busy |-> sclk_r == $past(cfg_r.clock_idle_polarity))
    else $error("clock not parked at idle");
  div_rate_a: assert property (busy && $past(busy) && $changed(sclk_r) |-> $past(div_cnt_r) == rate_r)
    else $error("clock toggled off divider");
  status_master_a: assert property (cfg_r.role |-> mode_v[1:0] == 2'h3)
    else $error("master empty bits not 1");
  slave_sel_a: assert property (nss_hist_r == '0 |=> mode_v[smsp_pkg::MS_SLV])
    else $error("selected bit not set");
  tcf_set_a: assert property (done_ev |=> tcf_r)
    else $error("completion flag missing");
  write_collision_flag_keep_a: assert property (wr_data && !transmit_buffer_empty_r |=> write_collision_flag_r && txbuf_r == $past(txbuf_r))
    else $error("collision not flagged");
  fault_stop_a: assert property (mfault |=> mode_fault_flag_r && !cfg_r.en && !cfg_r.role)
    else $error("mode fault not handled");
  ovr_set_a: assert property (done_ev && !cfg_r.role && !rx_empty_r |=> ovr_r && rxbuf_r == $past(rxbuf_r))
    else $error("overrun not flagged");
  nss_drive_a: assert property (cfg_r.wire_mode[1] |=> !slave_select_n_oe_b_out)
    else $error("select output not driven");
  tx_load_a: assert property (wr_data && transmit_buffer_empty_r |=> !transmit_buffer_empty_r ##1 !load[*1])
    else $error("transmit empty not cleared");
  off_idle_a: assert property (!cfg_r.en |=> !busy)
    else $error("disabled port busy");

  m_frame_c: cover property (done_ev && cfg_r.role);
  s_frame_c: cover property (done_ev && !cfg_r.role);
  ovr_c:     cover property (done_ev && !cfg_r.role && !rx_empty_r);
  fault_c:   cover property (mfault);

endmodule // smsp_top

// ### verification/smsp_far_slave.sv
// Far-side SPI slave model that answers the port while it is master.
// Assumes the bench loads the reply byte while the serial clock is idle.
`timescale 1ns/10ps

module smsp_far_slave (
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic       clock_phase_in,
  input  wire logic       clock_idle_polarity_in,
  input  wire logic       load_in,
  input  wire logic [7:0] reply_in,
  output logic            miso_out,
  output logic [7:0]      got_out
);
  logic [7:0] sh_r;

  always @(posedge load_in or posedge sclk_in or negedge sclk_in) begin
    if (load_in) begin
      sh_r     <= clock_phase_in ? reply_in : {reply_in[6:0], 1'b0};
      miso_out <= clock_phase_in ? ~reply_in[7] : reply_in[7];
    end else if ((sclk_in != clock_idle_polarity_in) ^ clock_phase_in) begin
      got_out <= {got_out[6:0], mosi_in};
    end else begin
      miso_out <= sh_r[7];
      sh_r     <= {sh_r[6:0], 1'b0};
    end
  end
endmodule // smsp_far_slave

// ### verification/test_spi_master_slave_port.sv
// Self-checking bench for the SPI master/slave port.
// Assumes a far-side slave model; the bench acts as external master itself.
`timescale 1ns/10ps

module test_spi_master_slave_port;
  logic        clk, rst_b, wr_s, rd_s, tb_sclk, tb_mosi, ssn, pload, clock_phase, clock_idle_polarity;
  logic        sclk_out, sclk_oe_b, mosi_out, mosi_oe_b, miso_out, miso_oe_b, ss_out, ss_oe_b, p_miso;
  logic [16:0] addr;
  logic [7:0]  wdata, rdata, preply, pgot, d, g, x1;
  wire         sclk_w = sclk_oe_b ? tb_sclk : sclk_out;
  wire         mosi_w = mosi_oe_b ? tb_mosi : mosi_out;
  wire         miso_w = miso_oe_b ? p_miso : miso_out;
  integer      seed = 32'hc31079c5;
  int          fail_count, n_checks, m, rt;

  smsp_top uut (.clk_sys_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .sclk_in(sclk_w), .sclk_out(sclk_out),
    .sclk_oe_b_out(sclk_oe_b), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_b_out(mosi_oe_b),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe_b_out(miso_oe_b), .slave_select_n_in(ssn),
    .slave_select_n_out(ss_out), .slave_select_n_oe_b_out(ss_oe_b));

  smsp_far_slave far (.sclk_in(sclk_w), .mosi_in(mosi_w), .clock_phase_in(clock_phase), .clock_idle_polarity_in(clock_idle_polarity),
    .load_in(pload), .reply_in(preply), .miso_out(p_miso), .got_out(pgot));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
    n_checks++;
    if (v !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic wr(input logic [14:0] ix, input logic [7:0] v);
    @(posedge clk);
    addr  <= {ix, 2'b00};
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [14:0] ix, input logic [7:0] mk, input logic [7:0] e);
    @(posedge clk);
    addr <= {ix, 2'b00};
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, e & mk, rdata & mk);
  endtask

  task automatic mframe(input logic [7:0] v, input logic [7:0] rep);
    int  tog, gap, bad, n;
    logic prev;
    preply = rep;
    pload = 1'b1;
    #1 pload = 1'b0;
    tog = 0;
    gap = 0;
    bad = 0;
    prev = sclk_out;
    wr(smsp_pkg::IDX_DATA, v);
    for (n = 0; n < 600 && tog < 16; n++) begin
      @(posedge clk);
      #1 gap++;
      if (sclk_out !== prev) begin
        if (tog > 0 && gap != rt + 1) bad++;
        tog++;
        gap = 0;
        prev = sclk_out;
      end
    end
    chk("sclk toggles", 8'h10, tog[7:0]);
    chk("sclk gaps", 8'h00, bad[7:0]);
    repeat (4) @(posedge clk);
    chk("far byte", v, pgot);
  endtask

  task automatic sframe(input logic [7:0] v, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      tb_mosi <= v[i];
      repeat (5) @(posedge clk);
      #1 q[i] = miso_w;
      @(posedge clk);
      tb_sclk <= 1'b1;
      repeat (6) @(posedge clk);
      tb_sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask

  initial begin
    #(40 * 40000);
    fail_count++;
    give_verdict();
  end

  initial begin
    {rst_b, wr_s, rd_s, tb_sclk, tb_mosi, pload, clock_phase, clock_idle_polarity} = 8'h00;
    {addr, wdata, preply} = 33'h0;
    ssn = 1'b1;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rchk("mode reset", smsp_pkg::IDX_MODE, 8'hFF, 8'h07);
    rchk("flag reset", smsp_pkg::IDX_FLAG, 8'hFF, 8'h02);
    rchk("rate reset", smsp_pkg::IDX_RATE, 8'hFF, 8'h00);
    rchk("data reset", smsp_pkg::IDX_DATA, 8'hFF, 8'h00);
    rchk("unmapped", 15'h4034, 8'hFF, 8'h00);
    for (m = 0; m < 4; m++) begin
      rt = 3 + ($unsigned($random(seed)) % 3);
      @(posedge clk);
      clock_phase = m[1];
      clock_idle_polarity = m[0];
      tb_sclk <= m[0];
      wr(smsp_pkg::IDX_FLAG, 8'h00);
      wr(smsp_pkg::IDX_RATE, rt[7:0]);
      rchk("rate", smsp_pkg::IDX_RATE, 8'hFF, rt[7:0]);
      wr(smsp_pkg::IDX_MODE, {2'b01, m[1], m[0], 4'hF});
      wr(smsp_pkg::IDX_FLAG, 8'h01);
      d = $random(seed);
      g = $random(seed);
      mframe(d, g);
      rchk("rx data", smsp_pkg::IDX_DATA, 8'hFF, g);
      rchk("done flag", smsp_pkg::IDX_FLAG, 8'h80, 8'h80);
      rchk("master stat", smsp_pkg::IDX_MODE, 8'hF3, {2'b01, m[1], m[0], 4'h3});
      chk("sclk idle", {7'h00, m[0]}, {7'h00, sclk_out});
      chk("sclk drive", 8'h00, {7'h00, sclk_oe_b});
    end
    wr(smsp_pkg::IDX_FLAG, 8'h81);
    rchk("flag keep", smsp_pkg::IDX_FLAG, 8'h80, 8'h80);
    wr(smsp_pkg::IDX_FLAG, 8'h01);
    rchk("flag clear", smsp_pkg::IDX_FLAG, 8'h80, 8'h00);
    d = $random(seed);
    wr(smsp_pkg::IDX_DATA, 8'h5A);
    rchk("busy on", smsp_pkg::IDX_MODE, 8'h80, 8'h80);
    wr(smsp_pkg::IDX_DATA, d);
    rchk("tx full", smsp_pkg::IDX_FLAG, 8'h02, 8'h00);
    wr(smsp_pkg::IDX_DATA, ~d);
    rchk("collision", smsp_pkg::IDX_FLAG, 8'h40, 8'h40);
    repeat (32 * (rt + 1) + 24) @(posedge clk);
    chk("kept byte", d, pgot);
    rchk("busy off", smsp_pkg::IDX_MODE, 8'h80, 8'h00);
    rchk("tx empty", smsp_pkg::IDX_FLAG, 8'h02, 8'h02);
    wr(smsp_pkg::IDX_FLAG, 8'h0C);
    repeat (2) @(posedge clk);
    chk("sel out hi", 8'h01, {6'h00, ss_oe_b, ss_out});
    wr(smsp_pkg::IDX_FLAG, 8'h08);
    repeat (2) @(posedge clk);
    chk("sel out lo", 8'h00, {6'h00, ss_oe_b, ss_out});
    wr(smsp_pkg::IDX_MODE, 8'h00);
    tb_sclk <= 1'b0;
    wr(smsp_pkg::IDX_FLAG, 8'h05);
    repeat (2) @(posedge clk);
    chk("sel input", 8'h01, {7'h00, ss_oe_b});
    ssn <= 1'b0;
    repeat (smsp_pkg::FILT_LEN + 6) @(posedge clk);
    rchk("selected", smsp_pkg::IDX_MODE, 8'h0C, 8'h08);
    d = $random(seed);
    x1 = $random(seed);
    wr(smsp_pkg::IDX_DATA, d);
    rchk("slv tx empty", smsp_pkg::IDX_FLAG, 8'h02, 8'h02);
    rchk("shift full", smsp_pkg::IDX_MODE, 8'h03, 8'h01);
    sframe(x1, g);
    chk("slave out", d, g);
    rchk("slv done", smsp_pkg::IDX_FLAG, 8'h90, 8'h80);
    rchk("rx unread", smsp_pkg::IDX_MODE, 8'h01, 8'h00);
    sframe(~x1, g);
    rchk("overrun", smsp_pkg::IDX_FLAG, 8'h10, 8'h10);
    rchk("rx kept", smsp_pkg::IDX_DATA, 8'hFF, x1);
    rchk("rx read", smsp_pkg::IDX_MODE, 8'h01, 8'h01);
    wr(smsp_pkg::IDX_FLAG, 8'h05);
    ssn <= 1'b1;
    repeat (smsp_pkg::FILT_LEN + 6) @(posedge clk);
    rchk("deselected", smsp_pkg::IDX_MODE, 8'h0C, 8'h04);
    sframe(x1, g);
    rchk("clk ignored", smsp_pkg::IDX_FLAG, 8'h80, 8'h00);
    ssn <= 1'b0;
    repeat (smsp_pkg::FILT_LEN + 6) @(posedge clk);
    wr(smsp_pkg::IDX_MODE, 8'h40);
    repeat (4) @(posedge clk);
    rchk("mode fault", smsp_pkg::IDX_FLAG, 8'h21, 8'h20);
    rchk("role cleared", smsp_pkg::IDX_MODE, 8'h40, 8'h00);
    give_verdict();
  end
endmodule // test_spi_master_slave_port
